// *** logic/vbs_pkg.sv ***
// Purpose: shared constants of the vbi slicer host access block
// Assumes: 8-bit register map reached over the serial host port
// Notes:   codes below are the line mode service codes (bits 3:0)
package vbs_pkg;
   // register map
   localparam logic [7:0] RES_FIRST     = 8'h90;
   localparam logic [7:0] RES_LAST      = 8'hAF;
   localparam logic [7:0] FIFO_PORT     = 8'hB0;
   localparam logic [7:0] CRAM_PORT     = 8'hC3;
   localparam logic [7:0] MODE_FIRST    = 8'hD0;
   localparam logic [7:0] MODE_LAST     = 8'hFC;
   localparam logic [7:0] MODE_RESET    = 8'hFF;
   localparam logic [7:0] RES_RESET     = 8'h00;
   localparam logic [7:0] READ_ZERO     = 8'h00;
   // serial bus device addresses (8-bit form, bit 0 is read/write)
   localparam logic [7:0] DEV_ADDR_HI   = 8'hBA;
   localparam logic [7:0] DEV_ADDR_LO   = 8'hB8;
   localparam logic [1:0] STRAP_WAIT    = 2'h3;
   // line window
   localparam logic [9:0] FIRST_LINE    = 10'h006;
   localparam logic [9:0] LAST_LINE     = 10'h01B;
   localparam logic [9:0] LATE_LINE     = 10'h018;
   localparam logic [5:0] LINES_FIELD   = 6'h16;
   localparam int         MODE_COUNT    = 45;
   localparam int         RES_COUNT     = 32;
   // ancillary packet header
   localparam logic [7:0] PRE_ZERO      = 8'h00;
   localparam logic [7:0] PRE_ONES      = 8'hFF;
   localparam logic [7:0] DID_F1_VBI    = 8'h91;
   localparam logic [7:0] DID_F1_LATE   = 8'h53;
   localparam logic [7:0] DID_F2_VBI    = 8'h55;
   localparam logic [7:0] DID_F2_LATE   = 8'h97;
   localparam logic [2:0] HDR_LAST      = 3'h7;
   // service codes
   typedef enum logic [3:0] {
      VBS_TT_SECAM  = 4'h0,
      VBS_TT_PAL_B  = 4'h1,
      VBS_TT_PAL_C  = 4'h2,
      VBS_TT_NTSC_B = 4'h3,
      VBS_TT_NTSC_C = 4'h4,
      VBS_TT_NTSC_D = 4'h5,
      VBS_CC_PAL    = 4'h6,
      VBS_CC_NTSC   = 4'h7,
      VBS_WSS_PAL   = 4'h8,
      VBS_WSS_NTSC  = 4'h9,
      VBS_INTERVAL_TIMECODE_SERVICE_PAL  = 4'hA,
      VBS_INTERVAL_TIMECODE_SERVICE_NTSC = 4'hB,
      VBS_VPS_PAL   = 4'hC,
      VBS_EPG_2X    = 4'hD,
      VBS_RESERVED  = 4'hE,
      VBS_FULL      = 4'hF
   } vbs_svc_e;
   // host port phases
   typedef enum logic [5:0] {
      HP_IDLE = 6'b000001,
      HP_ADDR = 6'b000010,
      HP_SUB  = 6'b000100,
      HP_WR   = 6'b001000,
      HP_RDP  = 6'b010000,
      HP_RD   = 6'b100000
   } vbs_hp_e;
   // packet writer states
   typedef enum logic [2:0] {
      PW_IDLE = 3'b001,
      PW_HDR  = 3'b010,
      PW_DATA = 3'b100
   } vbs_pw_e;
endpackage : vbs_pkg

// *** logic/vbs_mem.sv ***
// Purpose: simple dual-port byte memory with registered read
// Assumes: one write and one read port on the same clock
// Notes:   read data lag the read address by one cycle
`timescale 1ns/100ps
module vbs_mem #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 512,
   parameter int AW    = $clog2(DEPTH)
) (
   // clock
   input  wire logic             clk_sys,
   // write side
   input  wire logic             we,
   input  wire logic [AW-1:0]    waddr,
   input  wire logic [WIDTH-1:0] wdata,
   // read side
   input  wire logic [AW-1:0]    raddr,
   output logic      [WIDTH-1:0] rdata
);
   logic [WIDTH-1:0] mem [0:DEPTH-1];

   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("vbs_mem depth must be a power of two");
   end

   always_ff @(posedge clk_sys) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule : vbs_mem

// *** logic/vbs_vbi_slicer.sv ***
// Purpose: host access and result storage of the vbi slicer
// Assumes: upstream slicer core hands over one line's payload bytes
// Notes:   no memory initialisation; host loads the config ram
`timescale 1ns/100ps
module vbs_vbi_slicer #(
   parameter int FIFO_DEPTH = 512,
   parameter int CRAM_DEPTH = 256
) (
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst,
   // serial host port, open drain
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   output logic            sda_o,
   output logic            sda_oe,
   input  wire logic       bus_address_select,
   // sliced data from the slicer core
   input  wire logic       slice_start,
   input  wire logic       slice_field,
   input  wire logic [9:0] slice_line,
   input  wire logic [5:0] slice_words,
   input  wire logic       slice_error,
   input  wire logic       slice_valid,
   input  wire logic [7:0] slice_byte,
   input  wire logic       slice_last,
   output logic            slice_ready
);
   localparam int FAW = $clog2(FIFO_DEPTH);
   localparam int CAW = $clog2(CRAM_DEPTH);
   localparam logic [FAW:0] FIFO_HIGH = (FAW+1)'(FIFO_DEPTH - 2);
   if (FIFO_DEPTH < 16 || CRAM_DEPTH < 2 || CAW > 8) begin : g_bad_par
      $error("vbs_vbi_slicer depth parameters out of range");
   end
   // pin synchronisers and strap capture
   logic       scl_m, scl_s, scl_p, sda_m, sda_s, sda_p, sel_m, sel_s;
   logic [1:0] strap_cnt;
   logic       addr_hi;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         {scl_m, scl_s, scl_p} <= 3'h7;
         {sda_m, sda_s, sda_p} <= 3'h7;
         {sel_m, sel_s, addr_hi} <= 3'h0;
         strap_cnt             <= 2'h0;
      end else begin
         {scl_m, scl_s, scl_p} <= {scl_i, scl_m, scl_s};
         {sda_m, sda_s, sda_p} <= {sda_i, sda_m, sda_s};
         {sel_m, sel_s}        <= {bus_address_select, sel_m};
         // strap is caught once the synchroniser has settled
         if (strap_cnt != vbs_pkg::STRAP_WAIT) begin
            strap_cnt <= strap_cnt + 2'h1;
            addr_hi   <= sel_s;
         end
      end
   end
   wire [7:0] dev_addr = addr_hi ? vbs_pkg::DEV_ADDR_HI
                                 : vbs_pkg::DEV_ADDR_LO;
   wire scl_rise = scl_s & ~scl_p;
   wire scl_fall = ~scl_s & scl_p;
   wire bus_start = scl_s & scl_p & sda_p & ~sda_s;
   wire bus_stop  = scl_s & scl_p & ~sda_p & sda_s;
   // register storage
   logic [7:0]     mode_q   [0:vbs_pkg::MODE_COUNT-1];
   logic [7:0]     result_q [0:vbs_pkg::RES_COUNT-1];
   logic [CAW-1:0] cram_ptr;
   logic [FAW:0]   wp, rp;
   logic [7:0]     fifo_rdata, cram_rdata;
   // host port
   vbs_pkg::vbs_hp_e hp;
   logic [3:0] bitcnt;
   logic [7:0] shreg, tx, sub, acc_addr, acc_data;
   logic       mack, reg_wr, reg_rd;
   wire [FAW:0] used  = wp - rp;
   wire fifo_empty    = (wp == rp);
   wire fifo_full     = (used == (FAW+1)'(FIFO_DEPTH));
   wire sub_is_res    = (sub >= vbs_pkg::RES_FIRST) &&
                        (sub <= vbs_pkg::RES_LAST);
   wire sub_is_mode   = (sub >= vbs_pkg::MODE_FIRST) &&
                        (sub <= vbs_pkg::MODE_LAST);
   wire [7:0] res_idx  = sub - vbs_pkg::RES_FIRST;
   wire [7:0] mode_idx = sub - vbs_pkg::MODE_FIRST;
   wire [7:0] fifo_out = fifo_empty ? vbs_pkg::READ_ZERO : fifo_rdata;
   wire [7:0] rd_mux =
      sub_is_res                  ? result_q[res_idx[4:0]] :
      (sub == vbs_pkg::FIFO_PORT) ? fifo_out :
      (sub == vbs_pkg::CRAM_PORT) ? cram_rdata :
      sub_is_mode                 ? mode_q[mode_idx[5:0]] :
                                    vbs_pkg::READ_ZERO;
   // port addresses hold still so bursts stream through them
   wire port_sub = (sub == vbs_pkg::FIFO_PORT) ||
                   (sub == vbs_pkg::CRAM_PORT);
   wire [7:0] next_sub = port_sub ? sub : sub + 8'h01;
   wire addr_match = (shreg[7:1] == dev_addr[7:1]);
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         hp       <= vbs_pkg::HP_IDLE;
         bitcnt   <= 4'h0;
         {shreg, tx, sub}               <= 24'h000000;
         {mack, sda_oe, reg_wr, reg_rd} <= 4'h0;
         {acc_addr, acc_data}           <= 16'h0000;
      end else begin
         reg_wr <= 1'b0;
         reg_rd <= 1'b0;
         if (bus_start) begin
            hp     <= vbs_pkg::HP_ADDR;
            bitcnt <= 4'h0;
            sda_oe <= 1'b0;
         end else if (bus_stop) begin
            hp     <= vbs_pkg::HP_IDLE;
            sda_oe <= 1'b0;
         end else if (hp != vbs_pkg::HP_IDLE) begin
            if (scl_rise) begin
               bitcnt <= bitcnt + 4'h1;
               if (bitcnt < 4'h8) shreg <= {shreg[6:0], sda_s};
               else mack <= ~sda_s;
            end else if (scl_fall && bitcnt == 4'h9) begin
               bitcnt <= 4'h0;
               sda_oe <= 1'b0;
               if (hp == vbs_pkg::HP_RDP ||
                   (hp == vbs_pkg::HP_RD && mack)) begin
                  hp       <= vbs_pkg::HP_RD;
                  tx       <= rd_mux;
                  sda_oe   <= ~rd_mux[7];
                  reg_rd   <= 1'b1;
                  acc_addr <= sub;
                  sub      <= next_sub;
               end else if (hp == vbs_pkg::HP_RD) begin
                  hp <= vbs_pkg::HP_IDLE;
               end
            end else if (scl_fall && bitcnt == 4'h8) begin
               sda_oe <= 1'b0;
               unique case (hp)
                  vbs_pkg::HP_ADDR: begin
                     sda_oe <= addr_match;
                     if (!addr_match) hp <= vbs_pkg::HP_IDLE;
                     else if (shreg[0]) hp <= vbs_pkg::HP_RDP;
                     else hp <= vbs_pkg::HP_SUB;
                  end
                  vbs_pkg::HP_SUB: begin
                     sda_oe <= 1'b1;
                     sub    <= shreg;
                     hp     <= vbs_pkg::HP_WR;
                  end
                  vbs_pkg::HP_WR: begin
                     sda_oe   <= 1'b1;
                     reg_wr   <= 1'b1;
                     acc_addr <= sub;
                     acc_data <= shreg;
                     sub      <= next_sub;
                  end
                  vbs_pkg::HP_RDP, vbs_pkg::HP_RD, vbs_pkg::HP_IDLE: begin
                  end
               endcase
            end else if (scl_fall && hp == vbs_pkg::HP_RD &&
                         bitcnt != 4'h0) begin
               sda_oe <= ~tx[3'(4'h7 - bitcnt)];
            end
         end
      end
   end
   // config ram pointer
   wire cram_acc = (reg_wr | reg_rd) && (acc_addr == vbs_pkg::CRAM_PORT);
   wire cram_we  = reg_wr && (acc_addr == vbs_pkg::CRAM_PORT);
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cram_ptr <= '0;
         sda_o    <= 1'b0;
      end else if (cram_acc) begin
         cram_ptr <= cram_ptr + CAW'(1);
      end
   end
   // packet writer
   vbs_pkg::vbs_pw_e pw;
   logic [2:0] hdr_idx;
   logic [5:0] dcnt, cur_words;
   logic       discard, cur_field, cur_err;
   logic [9:0] cur_line;
   logic [7:0] cur_mode;
   wire        in_window = (slice_line >= vbs_pkg::FIRST_LINE) &&
                           (slice_line <= vbs_pkg::LAST_LINE);
   wire [5:0]  line_off  = 6'(slice_line - vbs_pkg::FIRST_LINE);
   wire [5:0]  line_idx  = slice_field ? line_off + vbs_pkg::LINES_FIELD
                                       : line_off;
   wire [7:0]  sel_mode  = in_window ? mode_q[line_idx] : vbs_pkg::MODE_RESET;
   wire [3:0]  sel_code  = sel_mode[3:0];
   // FFh parks a line; reserved code slices nothing
   wire        line_on   = in_window && (sel_mode != vbs_pkg::MODE_RESET) &&
                           (sel_code != vbs_pkg::VBS_RESERVED);
   wire        is_tt     = (cur_mode[3:0] <= vbs_pkg::VBS_TT_NTSC_D);
   wire        late      = (cur_line >= vbs_pkg::LATE_LINE);
   wire [7:0]  did       = cur_field
      ? (late ? vbs_pkg::DID_F2_LATE : vbs_pkg::DID_F2_VBI)
      : (late ? vbs_pkg::DID_F1_LATE : vbs_pkg::DID_F1_VBI);
   wire        sd_ep     = ^cur_mode[5:0];
   wire        nn_ep     = ^cur_words;
   wire [7:0]  hdr_byte  =
      (hdr_idx == 3'h0) ? vbs_pkg::PRE_ZERO :
      (hdr_idx <= 3'h2) ? vbs_pkg::PRE_ONES :
      (hdr_idx == 3'h3) ? did :
      (hdr_idx == 3'h4) ? {~sd_ep, sd_ep, cur_mode[5:0]} :
      (hdr_idx == 3'h5) ? {~nn_ep, nn_ep, cur_words} :
      (hdr_idx == 3'h6) ? cur_line[7:0] :
                          {3'h0, cur_err, 2'h0, cur_line[9:8]};
   wire        take      = slice_valid && slice_ready;
   wire        hdr_we    = (pw == vbs_pkg::PW_HDR) && !fifo_full;
   wire        fifo_we   = hdr_we || (take && !discard);
   wire [7:0]  fifo_wd   = hdr_we ? hdr_byte : slice_byte;
   wire        res_we    = take && !discard && !is_tt &&
                           (dcnt < 6'(vbs_pkg::RES_COUNT));
   // registered ready lags a cycle, so two bytes of margin
   wire        room      = discard || (used < FIFO_HIGH);
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pw          <= vbs_pkg::PW_IDLE;
         hdr_idx     <= 3'h0;
         dcnt        <= 6'h00;
         {discard, cur_field, cur_err} <= 3'h0;
         cur_line    <= 10'h000;
         cur_words   <= 6'h00;
         cur_mode    <= vbs_pkg::MODE_RESET;
         slice_ready <= 1'b0;
      end else begin
         slice_ready <= (pw == vbs_pkg::PW_DATA) && room &&
                        !(take && slice_last);
         unique case (pw)
            vbs_pkg::PW_IDLE: if (slice_start) begin
               cur_field <= slice_field;
               cur_line  <= slice_line;
               cur_words <= slice_words;
               cur_err   <= slice_error;
               cur_mode  <= sel_mode;
               discard   <= !line_on;
               hdr_idx   <= 3'h0;
               dcnt      <= 6'h00;
               pw        <= line_on ? vbs_pkg::PW_HDR : vbs_pkg::PW_DATA;
            end
            vbs_pkg::PW_HDR: if (!fifo_full) begin
               hdr_idx <= hdr_idx + 3'h1;
               if (hdr_idx == vbs_pkg::HDR_LAST) pw <= vbs_pkg::PW_DATA;
            end
            vbs_pkg::PW_DATA: if (take) begin
               if (dcnt != 6'h3F) dcnt <= dcnt + 6'h01;
               if (slice_last) pw <= vbs_pkg::PW_IDLE;
            end
         endcase
      end
   end
   // line mode and result registers, fifo pointers
   wire [7:0] wr_mode_idx = acc_addr - vbs_pkg::MODE_FIRST;
   wire mode_we = reg_wr && (acc_addr >= vbs_pkg::MODE_FIRST) &&
                  (acc_addr <= vbs_pkg::MODE_LAST);
   wire fifo_pop = reg_rd && (acc_addr == vbs_pkg::FIFO_PORT) && !fifo_empty;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < vbs_pkg::MODE_COUNT; i++)
            mode_q[i] <= vbs_pkg::MODE_RESET;
         for (int i = 0; i < vbs_pkg::RES_COUNT; i++)
            result_q[i] <= vbs_pkg::RES_RESET;
         wp <= '0;
         rp <= '0;
      end else begin
         if (mode_we) mode_q[wr_mode_idx[5:0]] <= acc_data;
         if (res_we) result_q[dcnt[4:0]] <= slice_byte;
         if (fifo_we) wp <= wp + (FAW+1)'(1);
         if (fifo_pop) rp <= rp + (FAW+1)'(1);
      end
   end
   vbs_mem #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo_mem (
      .clk_sys (clk_sys),
      .we      (fifo_we),
      .waddr   (wp[FAW-1:0]),
      .wdata   (fifo_wd),
      .raddr   (rp[FAW-1:0]),
      .rdata   (fifo_rdata)
   );
   vbs_mem #(.WIDTH(8), .DEPTH(CRAM_DEPTH)) u_cram_mem (
      .clk_sys (clk_sys),
      .we      (cram_we),
      .waddr   (cram_ptr),
      .wdata   (acc_data),
      .raddr   (cram_ptr),
      .rdata   (cram_rdata)
   );
endmodule : vbs_vbi_slicer

// *** dv/vbs_vbi_slicer_asserts.sv ***
// Purpose: port checks of the vbi slicer host access block
// Assumes: serial pins seen raw, the device syncs them inside
// Notes:   ack timing judged on raw scl, so bounds leave slack
`timescale 1ns/100ps
module vbs_vbi_slicer_asserts #(
   parameter int FIFO_DEPTH = 512,
   parameter int CRAM_DEPTH = 256
) (
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst,
   // serial port
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   input  wire logic       sda_o,
   input  wire logic       sda_oe,
   input  wire logic       bus_address_select,
   // slice stream
   input  wire logic       slice_start,
   input  wire logic       slice_field,
   input  wire logic [9:0] slice_line,
   input  wire logic [5:0] slice_words,
   input  wire logic       slice_error,
   input  wire logic       slice_valid,
   input  wire logic [7:0] slice_byte,
   input  wire logic       slice_last,
   input  wire logic       slice_ready
);
   logic       scl_q;
   logic       sda_q;
   logic [3:0] rises;
   wire logic  bus_start = scl_i && scl_q && sda_q && !sda_i;
   wire logic  out_line  = slice_line < vbs_pkg::FIRST_LINE ||
                           slice_line > vbs_pkg::LAST_LINE;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   // scl rises since the last start, saturating
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         rises <= 4'h0;
      end else begin
         scl_q <= scl_i;
         sda_q <= sda_i;
         if (bus_start)
            rises <= 4'h0;
         else if (scl_i && !scl_q && rises != 4'hF)
            rises <= rises + 4'h1;
      end
   end
   addr_ack_a: assert property ($rose(sda_oe) |-> rises >= 4'h8)
      else $error("sda pulled before a whole byte");
   ack_edge_a: assert property ($changed(sda_oe) |-> !$past(scl_i, 2))
      else $error("sda moved while scl high");
   sda_low_a: assert property (sda_o == 1'b0)
      else $error("sda driven high");
   reset_quiet_a: assert property ($fell(rst) |->
      (!sda_oe && !slice_ready) [*3])
      else $error("outputs active right after reset");
   ready_rise_a: assert property (slice_start && !slice_ready |->
      ##[1:16] slice_ready)
      else $error("payload never accepted");
   reject_fast_a: assert property (slice_start && !slice_ready &&
      out_line |-> ##2 slice_ready)
      else $error("line outside window not skipped");
   ready_drop_a: assert property (slice_valid && slice_ready &&
      slice_last |=> !slice_ready)
      else $error("ready held after last byte");
   ready_hold_a: assert property (slice_ready &&
      !(slice_valid && slice_last) |=> slice_ready)
      else $error("ready dropped mid line");
endmodule : vbs_vbi_slicer_asserts

bind vbs_vbi_slicer vbs_vbi_slicer_asserts #(
   .FIFO_DEPTH(FIFO_DEPTH), .CRAM_DEPTH(CRAM_DEPTH)
) vbs_vbi_slicer_asserts_inst (
   .clk_sys(clk_sys), .rst(rst), .scl_i(scl_i), .sda_i(sda_i),
   .sda_o(sda_o), .sda_oe(sda_oe),
   .bus_address_select(bus_address_select),
   .slice_start(slice_start), .slice_field(slice_field),
   .slice_line(slice_line), .slice_words(slice_words),
   .slice_error(slice_error), .slice_valid(slice_valid),
   .slice_byte(slice_byte), .slice_last(slice_last),
   .slice_ready(slice_ready)
);

// *** dv/vbs_host_model.sv ***
// Purpose: serial bus host for the slicer register port
// Assumes: pull-ups on both lines, single host
// Notes:   each bit phase lasts QTR clocks, above the sync delay
`timescale 1ns/100ps
module vbs_host_model (
   // clock
   input  wire logic clk_sys,
   // bus
   input  wire logic sda,
   output logic      scl_low,
   output logic      sda_low
);
   localparam int QTR = 4;
   logic [7:0] dev = 8'hBA;
   logic [7:0] rbuf [16];
   logic       addr_ack;
   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
   end
   task automatic q();
      repeat (QTR) @(posedge clk_sys);
   endtask : q
   task automatic bit_io(input logic b, output logic r);
      sda_low <= !b;
      q();
      scl_low <= 1'b0;
      q();
      r = sda;
      q();
      scl_low <= 1'b1;
      q();
   endtask : bit_io
   task automatic start();
      q();
      sda_low <= 1'b0;
      q();
      scl_low <= 1'b0;
      q();
      sda_low <= 1'b1;
      q();
      scl_low <= 1'b1;
      q();
   endtask : start
   task automatic stop();
      sda_low <= 1'b1;
      q();
      scl_low <= 1'b0;
      q();
      sda_low <= 1'b0;
      q();
   endtask : stop
   // rel high lets the device answer the ninth bit
   task automatic xfer(input logic [7:0] tx, input logic rel,
                       output logic [7:0] rx, output logic ok);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_io(tx[i], rx[i]);
      bit_io(rel, r);
      ok = !r;
   endtask : xfer
   task automatic wr(input logic [7:0] sub, input logic [7:0] d);
      logic [7:0] rx;
      logic       ok;
      start();
      xfer(dev, 1'b1, rx, addr_ack);
      xfer(sub, 1'b1, rx, ok);
      xfer(d, 1'b1, rx, ok);
      stop();
   endtask : wr
   task automatic rd(input logic [7:0] sub, input int n);
      logic [7:0] rx;
      logic       ok;
      start();
      xfer(dev, 1'b1, rx, addr_ack);
      xfer(sub, 1'b1, rx, ok);
      start();
      xfer(dev | 8'h01, 1'b1, rx, ok);
      for (int i = 0; i < n; i++)
         xfer(8'hFF, i == n - 1, rbuf[i], ok);
      stop();
   endtask : rd
endmodule : vbs_host_model

// *** dv/testbench.sv ***
// Purpose: self-checking bench of the vbi slicer host access block
// Assumes: host model carries all register traffic
// Notes:   all codes run on line 6, window edges run after
`timescale 1ns/100ps
module testbench;
   logic       clk_sys = 1'b0;
   logic       rst = 1'b1;
   logic       strap = 1'b1;
   logic       s_start = 1'b0;
   logic       s_field = 1'b0;
   logic [9:0] s_line = 10'h000;
   logic       s_err = 1'b0;
   logic       s_valid = 1'b0;
   logic [7:0] s_byte = 8'h00;
   logic       s_last = 1'b0;
   logic       sda_o;
   logic       sda_oe;
   logic       slice_ready;
   logic       scl_low;
   logic       sda_low;
   wire logic  scl = !scl_low;
   wire logic  sda = !sda_low && !(sda_oe && !sda_o);
   int         mismatches = 0;
   int         check_count = 0;
   logic [7:0] res [4] = '{default: 8'h00};
   always #4 clk_sys = !clk_sys;
   vbs_vbi_slicer vbs_vbi_slicer_inst (
      .clk_sys(clk_sys), .rst(rst), .scl_i(scl), .sda_i(sda),
      .sda_o(sda_o), .sda_oe(sda_oe), .bus_address_select(strap),
      .slice_start(s_start), .slice_field(s_field),
      .slice_line(s_line), .slice_words(6'h01), .slice_error(s_err),
      .slice_valid(s_valid), .slice_byte(s_byte),
      .slice_last(s_last), .slice_ready(slice_ready)
   );
   vbs_host_model vbs_host_model_inst (
      .clk_sys(clk_sys), .sda(sda), .scl_low(scl_low), .sda_low(sda_low)
   );
   task automatic summarize();
      if (mismatches == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : summarize
   task automatic chk(input string what, input logic [7:0] exp,
                      input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", what, exp, got);
         mismatches++;
      end
   endtask : chk
   task automatic rdc(input string what, input logic [7:0] sub,
                      input logic [7:0] exp);
      vbs_host_model_inst.rd(sub, 1);
      chk(what, exp, vbs_host_model_inst.rbuf[0]);
   endtask : rdc
   task automatic do_reset(input logic pin);
      @(posedge clk_sys);
      rst <= 1'b1;
      strap <= pin;
      repeat (8) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (8) @(posedge clk_sys);
   endtask : do_reset
   task automatic run_line(input logic f, input logic [9:0] ln,
                           input logic [3:0] code, input logic ok);
      logic [7:0] pay [4];
      logic [7:0] hdr [8];
      logic [5:0] m;
      logic [7:0] ra;
      int         n;
      m = {2'b00, code};
      ra = 8'hD0 + ln[7:0] - 8'h06 + (f ? 8'h16 : 8'h00);
      pay = '{{4'hC, code}, ln[7:0], 8'hA5, 8'h5A};
      hdr = '{8'h00, 8'hFF, 8'hFF,
              f ? (ln >= 10'h018 ? 8'h97 : 8'h55)
                : (ln >= 10'h018 ? 8'h53 : 8'h91),
              {~^m, ^m, m}, 8'h41, ln[7:0],
              {3'b000, code[0], 2'b00, ln[9:8]}};
      if (ln >= 10'h006 && ln <= 10'h01B)
         vbs_host_model_inst.wr(ra, {4'h0, code});
      @(posedge clk_sys);
      s_start <= 1'b1;
      s_field <= f;
      s_line <= ln;
      s_err <= code[0];
      @(posedge clk_sys);
      s_start <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         s_valid <= 1'b1;
         s_byte <= pay[i];
         s_last <= i == 3;
         n = 0;
         @(negedge clk_sys);
         while (slice_ready !== 1'b1 && n < 40) begin
            @(negedge clk_sys);
            n++;
         end
         if (n == 40) begin
            chk("slice ready", 8'h01, 8'h00);
            summarize();
         end
         @(posedge clk_sys);
      end
      s_valid <= 1'b0;
      s_last <= 1'b0;
      if (ok) begin
         vbs_host_model_inst.rd(vbs_pkg::FIFO_PORT, 13);
         for (int i = 0; i < 12; i++)
            chk("fifo byte", i < 8 ? hdr[i] : pay[i - 8],
                vbs_host_model_inst.rbuf[i]);
         chk("fifo drained", 8'h00, vbs_host_model_inst.rbuf[12]);
         // teletext leaves the result registers as they were
         if (code >= 4'h6)
            res = pay;
         vbs_host_model_inst.rd(vbs_pkg::RES_FIRST, 4);
         for (int i = 0; i < 4; i++)
            chk("result reg", res[i], vbs_host_model_inst.rbuf[i]);
      end else begin
         // a packet opens with 00 as well, so byte 1 tells
         vbs_host_model_inst.rd(vbs_pkg::FIFO_PORT, 2);
         chk("fifo skipped", 8'h00, vbs_host_model_inst.rbuf[1]);
      end
   endtask : run_line
   initial begin
      do_reset(1'b1);
      rdc("line mode reset", vbs_pkg::MODE_FIRST, 8'hFF);
      rdc("result reset", vbs_pkg::RES_FIRST, 8'h00);
      rdc("fifo idle", vbs_pkg::FIFO_PORT, 8'h00);
      rdc("unmapped", 8'h10, 8'h00);
      vbs_host_model_inst.wr(vbs_pkg::RES_FIRST, 8'h77);
      rdc("result read only", vbs_pkg::RES_FIRST, 8'h00);
      vbs_host_model_inst.wr(vbs_pkg::MODE_LAST, 8'h3C);
      rdc("last line mode", vbs_pkg::MODE_LAST, 8'h3C);
      vbs_host_model_inst.wr(vbs_pkg::MODE_LAST, 8'hFF);
      for (int i = 0; i < 4; i++)
         vbs_host_model_inst.wr(vbs_pkg::CRAM_PORT, 8'h30 + 8'(i));
      do_reset(1'b0);
      vbs_host_model_inst.wr(vbs_pkg::MODE_LAST, 8'hFF);
      chk("high addr ack", 8'h00, {7'h00, vbs_host_model_inst.addr_ack});
      vbs_host_model_inst.dev = 8'hB8;
      vbs_host_model_inst.rd(vbs_pkg::CRAM_PORT, 4);
      chk("low addr ack", 8'h01, {7'h00, vbs_host_model_inst.addr_ack});
      for (int i = 0; i < 4; i++)
         chk("config ram", 8'h30 + 8'(i), vbs_host_model_inst.rbuf[i]);
      for (int c = 0; c < 16; c++)
         run_line(1'b0, 10'h006, 4'(c), c != 14);
      run_line(1'b0, 10'h005, 4'h7, 1'b0);
      run_line(1'b0, 10'h018, 4'h9, 1'b1);
      run_line(1'b1, 10'h01B, 4'hC, 1'b1);
      run_line(1'b1, 10'h01C, 4'h7, 1'b0);
      summarize();
   end
endmodule : testbench
